/* File: core/ref_clock_pkg.sv */
package ref_clock_pkg;
	localparam int          NUM_CHANNELS   = 22;
	localparam int          ADDR_W         = 4;
	localparam int          DATA_W         = 8;
	localparam int          SRC_W          = 5;
	localparam int          DIV_W          = 8;
	// register offsets
	localparam logic [3:0]  OFF_CTRL_A     = 4'h0;
	localparam logic [3:0]  OFF_CTRL_B     = 4'h1;
	localparam logic [3:0]  OFF_DIV_A      = 4'h2;
	localparam logic [3:0]  OFF_DIV_B      = 4'h3;
	localparam logic [3:0]  OFF_STATUS     = 4'h4;
	// control register fields
	localparam int          BIT_ENABLE     = 6;
	localparam int          BIT_RATE       = 5;
	localparam int          SRC_LSB        = 0;
	// source codes: 0..21 recovered channel clocks
	localparam logic [4:0]  SRC_EXTERNAL   = 5'h16;
	localparam logic [4:0]  SRC_FREE_RUN   = 5'h17;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  DIV_RESET      = 8'h00;

	typedef struct packed {
		logic             enable;  // output drives pin
		logic             rate;    // 0: t1/j1 1.544 MHz, 1: e1 2.048 MHz; only stored and read back, the output frequency comes from the divider
		logic [SRC_W-1:0] src;
	} ref_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;
endpackage : ref_clock_pkg

/* File: core/ref_clock_out.sv */
// What this block does
// - output A carries a chosen channel recovered clock, external clock A, or free-running clock.
// - output A frequency is set by software through a divider, not fixed by source.
// - enable bit 6 of reference A control gates output A; cleared means high impedance.
// - output B carries a chosen channel recovered clock, external clock B, or free-running clock.
// - enable bit 6 of reference B control gates output B; cleared means high impedance.
//
// Our own choices: strobed register access and the placing of the registers.
module ref_clock_out
	import ref_clock_pkg::*;
(
	input  wire logic                    clk,                  // 40 MHz
	input  wire logic                    reset_n,              // synchronous, active low
	input  wire reg_req_t                req,                  // register request
	output logic      [DATA_W-1:0]       rdata,                // read data, cycle after rd
	input  wire logic [NUM_CHANNELS-1:0] rec_clock_in,         // recovered line clocks
	input  wire logic                    ext_clock_in_a,       // external clock A pin
	input  wire logic                    ext_clock_in_b,       // external clock B pin
	output logic                         ref_clock_out_a,      // reference A level
	output logic                         ref_clock_out_a_oe,   // reference A drive enable
	output logic                         ref_clock_out_b,      // reference B level
	output logic                         ref_clock_out_b_oe    // reference B drive enable
);

	ref_ctrl_t                   ctrl_q [2];
	logic [DIV_W-1:0]            div_q  [2];
	logic [DIV_W-1:0]            cnt_q  [2];
	logic [1:0]                  out_q;
	logic [1:0]                  oe_q;
	logic [1:0]                  prev_q;
	logic [1:0]                  sel_lvl;
	logic [1:0]                  rise;
	logic [DATA_W-1:0]           rdata_q;
	logic [NUM_CHANNELS+1:0]     meta_q;
	logic [NUM_CHANNELS+1:0]     sync_q;
	logic                        free_q;

	// all clock inputs are asynchronous to clk: two flops before any use
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {ext_clock_in_b, ext_clock_in_a, rec_clock_in};
			sync_q <= meta_q;
		end
	end

	// free-running source: clk/2, independent of any line
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			free_q <= 1'b0;
		end else begin
			free_q <= ~free_q;
		end
	end

	function automatic logic pick_source(input logic [SRC_W-1:0] src,
	                                     input logic [NUM_CHANNELS-1:0] chans,
	                                     input logic ext, input logic free_run);
		logic lvl;
		lvl = 1'b0;
		if (src == SRC_EXTERNAL) begin
			lvl = ext;
		end else if (src == SRC_FREE_RUN) begin
			lvl = free_run;
		end else if (32'(src) < NUM_CHANNELS) begin
			lvl = chans[src];
		end
		return lvl;
	endfunction : pick_source

	function automatic logic [3:0] ctrl_offset(input int idx);
		return (idx == 0) ? OFF_CTRL_A : OFF_CTRL_B;
	endfunction : ctrl_offset

	function automatic logic [3:0] div_offset(input int idx);
		return (idx == 0) ? OFF_DIV_A : OFF_DIV_B;
	endfunction : div_offset

	for (genvar i = 0; i < 2; i++) begin : g_ref
		logic ctrl_wr;
		assign ctrl_wr = req.wr && (req.addr == ctrl_offset(i));
		logic div_wr;
		assign div_wr  = req.wr && (req.addr == div_offset(i));

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				ctrl_q[i] <= ref_ctrl_t'(CTRL_RESET[6:0]);
			end else if (ctrl_wr) begin
				ctrl_q[i].enable <= req.wdata[BIT_ENABLE];
				ctrl_q[i].rate   <= req.wdata[BIT_RATE];
				ctrl_q[i].src    <= req.wdata[SRC_LSB +: SRC_W];
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				div_q[i] <= DIV_RESET;
			end else if (div_wr) begin
				div_q[i] <= req.wdata;
			end
		end

		// out-of-range channel codes select a quiet low source
		assign sel_lvl[i] = pick_source(ctrl_q[i].src, sync_q[NUM_CHANNELS-1:0],
		                                sync_q[NUM_CHANNELS+i], free_q);
		assign rise[i]    = sel_lvl[i] & ~prev_q[i];

		// output toggles once per (div+1) source rising edges: f_out = f_src/(2*(div+1));
		// a source or ratio change restarts the count so no runt from the old ratio;
		// without the ratio restart a smaller div would leave cnt above it for up to 255 edges
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				prev_q[i] <= 1'b0;
				cnt_q[i]  <= '0;
				out_q[i]  <= 1'b0;
			end else begin
				prev_q[i] <= sel_lvl[i];
				if (ctrl_wr || div_wr) begin
					cnt_q[i] <= '0;
				end else if (rise[i]) begin
					if (cnt_q[i] == div_q[i]) begin
						cnt_q[i] <= '0;
						out_q[i] <= ~out_q[i];
					end else begin
						cnt_q[i] <= cnt_q[i] + 1'b1;
					end
				end
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				oe_q[i] <= 1'b0;
			end else begin
				oe_q[i] <= ctrl_q[i].enable;
			end
		end

		a_oe_tracks_enable: assert property (@(posedge clk) disable iff (!reset_n)
			ctrl_wr ##1 1'b1 |=> (oe_q[i] == $past(req.wdata[BIT_ENABLE], 2)))
			else $error("drive enable does not follow enable bit");

		sequence s_source_rise;
			rise[i] && !ctrl_wr && !div_wr;
		endsequence

		// free-run selected for three samples, so prev_q already holds a free-run level
		sequence s_free_held;
			(ctrl_q[i].src == SRC_FREE_RUN) && $stable(ctrl_q[i].src)
			&& ($past(ctrl_q[i].src, 2) == SRC_FREE_RUN);
		endsequence

		a_toggle_has_cause: assert property (@(posedge clk) disable iff (!reset_n)
			$changed(out_q[i]) && $past(reset_n)
			|-> $past(rise[i] && !ctrl_wr && !div_wr && (cnt_q[i] == div_q[i])))
			else $error("reference output toggled without divider terminal count");

		a_div_toggles: assert property (@(posedge clk) disable iff (!reset_n)
			s_source_rise and (cnt_q[i] == div_q[i]) |=> $changed(out_q[i]))
			else $error("reference output missed divider terminal count");

		a_free_run_edges: assert property (@(posedge clk) disable iff (!reset_n)
			s_free_held |-> rise[i] || $past(rise[i]))
			else $error("free-running source produced no edge");

		a_level_holds: assert property (@(posedge clk) disable iff (!reset_n)
			!(rise[i] && !ctrl_wr && !div_wr) |=> $stable(out_q[i]))
			else $error("reference output moved without a source edge");

		a_count_in_range: assert property (@(posedge clk) disable iff (!reset_n)
			cnt_q[i] <= div_q[i])
			else $error("divider count passed its terminal value");

		a_count_restart: assert property (@(posedge clk) disable iff (!reset_n)
			ctrl_wr || div_wr |=> cnt_q[i] == '0)
			else $error("divider count not restarted by a register write");

		a_ext_two_flops: assert property (@(posedge clk) disable iff (!reset_n)
			(ctrl_q[i].src == SRC_EXTERNAL) && $past(reset_n) && $past(reset_n, 2)
			|-> sel_lvl[i] == $past(i == 0 ? ext_clock_in_a : ext_clock_in_b, 2))
			else $error("external source not taken through two flops");

		a_quiet_code: assert property (@(posedge clk) disable iff (!reset_n)
			(ctrl_q[i].src > SRC_FREE_RUN) |-> !sel_lvl[i])
			else $error("unused source code did not select a quiet low");
	end

	assign ref_clock_out_a    = out_q[0];
	assign ref_clock_out_a_oe = oe_q[0];
	assign ref_clock_out_b    = out_q[1];
	assign ref_clock_out_b_oe = oe_q[1];

	// read port: unmapped offsets read zero; reserved bit 7 reads zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (req.rd) begin
			unique case (req.addr)
				OFF_CTRL_A: rdata_q <= {1'b0, ctrl_q[0]};
				OFF_CTRL_B: rdata_q <= {1'b0, ctrl_q[1]};
				OFF_DIV_A:  rdata_q <= div_q[0];
				OFF_DIV_B:  rdata_q <= div_q[1];
				OFF_STATUS: rdata_q <= {4'h0, oe_q[1], out_q[1], oe_q[0], out_q[0]};
				default:    rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end
	assign rdata = rdata_q;

	a_read_ctrl_a: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd && (req.addr == OFF_CTRL_A) && !req.wr |=> (rdata[BIT_ENABLE] == oe_q[0]))
		else $error("control A readback disagrees with output enable");

	a_read_ctrl_b: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd && (req.addr == OFF_CTRL_B) && !req.wr |=> (rdata[BIT_ENABLE] == oe_q[1]))
		else $error("control B readback disagrees with output enable");

	a_read_idle_zero: assert property (@(posedge clk) disable iff (!reset_n)
		!req.rd |=> rdata == '0)
		else $error("read data present without a read strobe");

endmodule : ref_clock_out

/* File: verification/ref_clock_sink.sv */
// downstream consumer of one reference clock pin; counts rising edges while driven
module ref_clock_sink (
	input  wire logic clk,    // bench clock
	input  wire logic level,  // level from the block
	input  wire logic oe,     // drive enable from the block
	input  wire logic clear,  // restart the edge count
	output logic      pin,    // resolved pin level
	output int        rises   // rising edges seen while driven
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q;
	// a floating pin has no pull, so show a moving value rather than the last one
	always_comb pin = oe ? level : ~last_q;
	always_ff @(posedge clk) begin
		last_q <= pin;
		if (clear)
			rises <= 0;
		else if (oe && pin && !last_q)
			rises <= rises + 1;
	end
endmodule : ref_clock_sink

/* File: verification/tb_top.sv */
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
	$display("[ERR] %0t mismatch %h vs %h", $time, got, exp); end end
module tb_top import ref_clock_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, clear = 0, src_tgl = 0, oe_a, oe_b, out_a, out_b, pin_a, pin_b;
	reg_req_t req = '0;
	logic [DATA_W-1:0] rdata;
	int err_total = 0, tests_run = 0, cyc = 0, chan = 0, rises_a, rises_b;
	logic [NUM_CHANNELS-1:0] rec;
	assign rec = NUM_CHANNELS'(src_tgl) << chan;
	ref_clock_out i_ref_clock_out (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
		.rec_clock_in(rec), .ext_clock_in_a(src_tgl), .ext_clock_in_b(src_tgl),
		.ref_clock_out_a(out_a), .ref_clock_out_a_oe(oe_a),
		.ref_clock_out_b(out_b), .ref_clock_out_b_oe(oe_b));
	ref_clock_sink i_ref_clock_sink_a (.clk(clk), .level(out_a), .oe(oe_a), .clear(clear),
		.pin(pin_a), .rises(rises_a));
	ref_clock_sink i_ref_clock_sink_b (.clk(clk), .level(out_b), .oe(oe_b), .clear(clear),
		.pin(pin_b), .rises(rises_b));
	initial forever #12.5 clk = ~clk;
	// source clocks rise every 8 cycles; the ceiling is several times the whole run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc[1:0] == 2'd3) src_tgl <= ~src_tgl;
		if (cyc == 3000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) req <= {a, d, 2'b10};
		@(posedge clk) req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk) req <= {a, 8'h00, 2'b01};
		@(posedge clk) req.rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask : rd
	task automatic count(input int n);
		@(posedge clk) clear <= 1'b1;
		@(posedge clk) clear <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask : count
	task automatic t_reset();
		#1 `CHK({oe_a, oe_b}, 2'b00)
		rd(OFF_CTRL_A, CTRL_RESET);
		rd(OFF_CTRL_B, CTRL_RESET);
		rd(4'hf, 8'h00);
	endtask : t_reset
	task automatic t_free_a();
		wr(OFF_DIV_A, 8'h00);
		wr(OFF_CTRL_A, {2'b01, 1'b0, SRC_FREE_RUN});
		rd(OFF_CTRL_A, {2'b01, 1'b0, SRC_FREE_RUN});
		`CHK(oe_a, 1'b1)
		count(40);
		`CHK(rises_a inside {[9:11]}, 1'b1)
	endtask : t_free_a
	task automatic t_divided();
		@(posedge clk) chan <= NUM_CHANNELS - 1;
		wr(OFF_DIV_A, 8'h01);
		wr(OFF_CTRL_A, {2'b01, 1'b0, 5'd21});
		wr(OFF_DIV_B, 8'h01);
		wr(OFF_CTRL_B, {2'b01, 1'b1, SRC_EXTERNAL});
		rd(OFF_CTRL_B, {2'b01, 1'b1, SRC_EXTERNAL});
		count(128);
		`CHK(rises_a inside {[3:5]}, 1'b1)
		`CHK(rises_b inside {[3:5]}, 1'b1)
	endtask : t_divided
	task automatic t_chan_quiet();
		@(posedge clk) chan <= 0;
		wr(OFF_DIV_B, 8'h00);
		wr(OFF_CTRL_B, {2'b01, 1'b0, 5'd0});
		wr(OFF_CTRL_A, {2'b01, 1'b0, 5'h1f});
		count(64);
		`CHK(rises_b inside {[3:5]}, 1'b1)
		`CHK(rises_a, 0)
	endtask : t_chan_quiet
	task automatic t_disable();
		wr(OFF_CTRL_A, {3'b000, SRC_FREE_RUN});
		wr(OFF_CTRL_B, {3'b001, SRC_EXTERNAL});
		count(40);
		`CHK({oe_a, oe_b}, 2'b00)
		`CHK(rises_a + rises_b, 0)
	endtask : t_disable
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_free_a();
		t_divided();
		t_chan_quiet();
		t_disable();
		end_of_test();
	end
endmodule : tb_top
